// *** rtl/msp_memory_select.v ***
`include "msp_consts.vh"

// Summary of operation
// - Secondary flash wins over main flash overlap.
// - SRAM, control, peripheral selects beat both flashes.
// - Routing register steers strobes to memories.
// - Reset reloads routing from non-volatile default.
// - Core may overwrite routing until reset.
// - Bit 4 lets data strobes reach main.
// - Bit 3 lets data strobes reach secondary.
// - Bit 2 lets code fetch reach main.
// - Bit 1 lets code fetch reach secondary.
// - Bit 0 lets code fetch reach SRAM.
// - SRAM always reachable in data space.
// - Control block answers data strobes only.
// - Control registers at base plus offset; unused zero.
// - Pin input registers read pins, ignore writes.
// - Mode registers select I/O or address; readable.
// - Output register sets pin_out_o; cell_drives_pin_i is unused.
// - Direction bit one output, zero input.
// - Driver-enable status reads enables, ignores writes.
// - Mask bit one blocks output cell access.
// - Power register three bit one only reset-clears.
module msp_memory_select #(
    parameter [7:0] ROUTE_DEFAULT = 8'h0c,
    parameter [7:0] FLASH_PROT = 8'h00,
    parameter [7:0] SEC_PROT = 8'h00
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Core bus
    input wire [15:0] addr_i,
    input wire [7:0] wdata_i,
    input wire rd_strobe_i,
    input wire wr_strobe_i,
    input wire code_fetch_strobe_i,
    input wire [15:0] ctrl_base_i,
    // Sector selects
    input wire [7:0] main_flash_sector_select_i,
    input wire [3:0] secondary_flash_sector_select_i,
    input wire sram_select_i,
    input wire peripheral_io_select_i,
    // Memory data
    input wire [7:0] main_rdata_i,
    input wire [7:0] sec_rdata_i,
    input wire [7:0] sram_rdata_i,
    input wire [7:0] periph_rdata_i,
    // Port pins and cells
    input wire [31:0] pin_level_i,
    input wire [23:0] input_cell_i,
    input wire [15:0] output_cell_i,
    input wire [31:0] cell_drives_pin_i,
    input wire [31:0] driver_enable_i,
    // Targets
    output reg main_flash_en_o,
    output reg sec_flash_en_o,
    output reg sram_en_o,
    output reg periph_en_o,
    output reg [2:0] target_o,
    output reg [7:0] rdata_o,
    output reg rdata_valid_o,
    // Register outputs
    output reg [31:0] pin_out_o,
    output reg [31:0] pin_dir_o,
    output reg [15:0] addr_out_mode_o,
    output reg [31:0] driver_type_o,
    output reg [15:0] output_cell_load_o,
    output reg [1:0] output_cell_load_en_o,
    output reg [7:0] memory_page_o,
    output reg peripheral_io_enable_o,
    output reg [7:0] power_zero_o,
    output reg [7:0] power_two_o,
    output reg [7:0] power_three_o
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    wire [31:0] pins_sync;
    wire [15:0] ctrl_span;
    wire ctrl_select;
    wire data_strobe;
    wire [7:0] off;
    wire [2:0] target;
    wire [7:0] route;
    wire ctrl_wr;

    msp_pin_sync #(
        .WIDTH(32)
    ) u_pin_sync (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .async_i(pin_level_i),
        .sync_o(pins_sync)
    );

    assign ctrl_span = addr_i - ctrl_base_i;
    assign ctrl_select = (addr_i >= ctrl_base_i) && (ctrl_span[15:8] == 8'h00);
    assign off = ctrl_span[7:0];
    assign data_strobe = rd_strobe_i | wr_strobe_i;

    msp_target_select u_target_select (
        .main_flash_sector_select_i(main_flash_sector_select_i),
        .secondary_flash_sector_select_i(secondary_flash_sector_select_i),
        .sram_select_i(sram_select_i),
        .ctrl_select_i(ctrl_select),
        .peripheral_io_select_i(peripheral_io_select_i & peripheral_io_enable_o),
        .data_strobe_i(data_strobe),
        .code_fetch_strobe_i(code_fetch_strobe_i),
        .route_i(route),
        .target_o(target)
    );

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [7:0] route_reg;
    reg [15:0] mask_reg;
    reg wr_seen_reg;

    assign route = route_reg;
    // Only the first cycle of a held write strobe is taken.
    assign ctrl_wr = wr_strobe_i & ~wr_seen_reg & (target == `MSP_TGT_CTRL);

    always @(posedge clock_i) begin
        if (srst_i) begin
            wr_seen_reg <= 1'b0;
        end else begin
            wr_seen_reg <= wr_strobe_i;
        end
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            route_reg <= ROUTE_DEFAULT;
            mask_reg <= {2{`MSP_RST_BYTE}};
            pin_out_o <= {4{`MSP_RST_BYTE}};
            pin_dir_o <= {4{`MSP_RST_BYTE}};
            addr_out_mode_o <= {2{`MSP_RST_BYTE}};
            driver_type_o <= {4{`MSP_RST_BYTE}};
            memory_page_o <= `MSP_RST_BYTE;
            power_zero_o <= `MSP_RST_BYTE;
            power_two_o <= `MSP_RST_BYTE;
            power_three_o <= `MSP_RST_BYTE;
            output_cell_load_o <= {2{`MSP_RST_BYTE}};
            output_cell_load_en_o <= 2'b00;
            peripheral_io_enable_o <= ROUTE_DEFAULT[7];
        end else begin
            output_cell_load_en_o <= 2'b00;
            if (ctrl_wr) begin
                case (off)
                    `MSP_OFF_A_MODE: addr_out_mode_o[7:0] <= wdata_i;
                    `MSP_OFF_B_MODE: addr_out_mode_o[15:8] <= wdata_i;
                    `MSP_OFF_A_OUT: pin_out_o[7:0] <= wdata_i;
                    `MSP_OFF_B_OUT: pin_out_o[15:8] <= wdata_i;
                    `MSP_OFF_C_OUT: pin_out_o[23:16] <= wdata_i;
                    `MSP_OFF_D_OUT: pin_out_o[31:24] <= wdata_i;
                    `MSP_OFF_A_DIR: pin_dir_o[7:0] <= wdata_i;
                    `MSP_OFF_B_DIR: pin_dir_o[15:8] <= wdata_i;
                    `MSP_OFF_C_DIR: pin_dir_o[23:16] <= wdata_i;
                    `MSP_OFF_D_DIR: pin_dir_o[31:24] <= wdata_i;
                    `MSP_OFF_A_DRV: driver_type_o[7:0] <= wdata_i;
                    `MSP_OFF_B_DRV: driver_type_o[15:8] <= wdata_i;
                    `MSP_OFF_C_DRV: driver_type_o[23:16] <= wdata_i;
                    `MSP_OFF_D_DRV: driver_type_o[31:24] <= wdata_i;
                    // Masked bits reload their present value, so a write cannot change them.
                    `MSP_OFF_OC_ONE: begin
                        output_cell_load_o[7:0] <= (wdata_i & ~mask_reg[7:0]) |
                                                   (output_cell_i[7:0] & mask_reg[7:0]);
                        output_cell_load_en_o[0] <= 1'b1;
                    end
                    `MSP_OFF_OC_TWO: begin
                        output_cell_load_o[15:8] <= (wdata_i & ~mask_reg[15:8]) |
                                                    (output_cell_i[15:8] & mask_reg[15:8]);
                        output_cell_load_en_o[1] <= 1'b1;
                    end
                    `MSP_OFF_MASK_ONE: mask_reg[7:0] <= wdata_i;
                    `MSP_OFF_MASK_TWO: mask_reg[15:8] <= wdata_i;
                    `MSP_OFF_PWR_ZERO: power_zero_o <= wdata_i;
                    `MSP_OFF_PWR_TWO: power_two_o <= wdata_i;
                    `MSP_OFF_PWR_THREE: begin
                        power_three_o <= wdata_i | (power_three_o & 8'h02);
                    end
                    `MSP_OFF_PAGE: memory_page_o <= wdata_i;
                    `MSP_OFF_ROUTE: begin
                        route_reg <= wdata_i;
                        peripheral_io_enable_o <= wdata_i[7];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Output cell masking
    // ****************************************************************
    wire [15:0] cell_masked;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_mask
            assign cell_masked[gi] = mask_reg[gi] ? 1'b0 : output_cell_i[gi];
        end
    endgenerate

    // ****************************************************************
    // Control block read data
    // ****************************************************************
    reg [7:0] ctrl_rdata;

    always @* begin
        case (off)
            `MSP_OFF_A_IN: ctrl_rdata = pins_sync[7:0];
            `MSP_OFF_B_IN: ctrl_rdata = pins_sync[15:8];
            `MSP_OFF_C_IN: ctrl_rdata = pins_sync[23:16];
            `MSP_OFF_D_IN: ctrl_rdata = pins_sync[31:24];
            `MSP_OFF_A_MODE: ctrl_rdata = addr_out_mode_o[7:0];
            `MSP_OFF_B_MODE: ctrl_rdata = addr_out_mode_o[15:8];
            `MSP_OFF_A_OUT: ctrl_rdata = pin_out_o[7:0];
            `MSP_OFF_B_OUT: ctrl_rdata = pin_out_o[15:8];
            `MSP_OFF_C_OUT: ctrl_rdata = pin_out_o[23:16];
            `MSP_OFF_D_OUT: ctrl_rdata = pin_out_o[31:24];
            `MSP_OFF_A_DIR: ctrl_rdata = pin_dir_o[7:0];
            `MSP_OFF_B_DIR: ctrl_rdata = pin_dir_o[15:8];
            `MSP_OFF_C_DIR: ctrl_rdata = pin_dir_o[23:16];
            `MSP_OFF_D_DIR: ctrl_rdata = pin_dir_o[31:24];
            `MSP_OFF_A_DRV: ctrl_rdata = driver_type_o[7:0];
            `MSP_OFF_B_DRV: ctrl_rdata = driver_type_o[15:8];
            `MSP_OFF_C_DRV: ctrl_rdata = driver_type_o[23:16];
            `MSP_OFF_D_DRV: ctrl_rdata = driver_type_o[31:24];
            `MSP_OFF_A_IC: ctrl_rdata = input_cell_i[7:0];
            `MSP_OFF_B_IC: ctrl_rdata = input_cell_i[15:8];
            `MSP_OFF_C_IC: ctrl_rdata = input_cell_i[23:16];
            `MSP_OFF_A_EN: ctrl_rdata = driver_enable_i[7:0];
            `MSP_OFF_B_EN: ctrl_rdata = driver_enable_i[15:8];
            `MSP_OFF_C_EN: ctrl_rdata = driver_enable_i[23:16];
            `MSP_OFF_D_EN: ctrl_rdata = driver_enable_i[31:24];
            `MSP_OFF_OC_ONE: ctrl_rdata = cell_masked[7:0];
            `MSP_OFF_OC_TWO: ctrl_rdata = cell_masked[15:8];
            `MSP_OFF_MASK_ONE: ctrl_rdata = mask_reg[7:0];
            `MSP_OFF_MASK_TWO: ctrl_rdata = mask_reg[15:8];
            `MSP_OFF_PWR_ZERO: ctrl_rdata = power_zero_o;
            `MSP_OFF_PWR_TWO: ctrl_rdata = power_two_o;
            `MSP_OFF_FL_PROT: ctrl_rdata = FLASH_PROT;
            `MSP_OFF_SEC_PROT: ctrl_rdata = SEC_PROT;
            `MSP_OFF_PWR_THREE: ctrl_rdata = power_three_o;
            `MSP_OFF_PAGE: ctrl_rdata = memory_page_o;
            `MSP_OFF_ROUTE: ctrl_rdata = {peripheral_io_enable_o, route_reg[6:0]};
            default: ctrl_rdata = 8'h00;
        endcase
    end

    // ****************************************************************
    // Target enables and returned data
    // ****************************************************************
    reg [7:0] rdata_next;

    always @* begin
        case (target)
            `MSP_TGT_MAIN: rdata_next = main_rdata_i;
            `MSP_TGT_SEC: rdata_next = sec_rdata_i;
            `MSP_TGT_SRAM: rdata_next = sram_rdata_i;
            `MSP_TGT_CTRL: rdata_next = ctrl_rdata;
            `MSP_TGT_PERIPH: rdata_next = periph_rdata_i;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clock_i) begin
        if (srst_i) begin
            main_flash_en_o <= 1'b0;
            sec_flash_en_o <= 1'b0;
            sram_en_o <= 1'b0;
            periph_en_o <= 1'b0;
            target_o <= `MSP_TGT_NONE;
            rdata_o <= 8'h00;
            rdata_valid_o <= 1'b0;
        end else begin
            main_flash_en_o <= (target == `MSP_TGT_MAIN);
            sec_flash_en_o <= (target == `MSP_TGT_SEC);
            sram_en_o <= (target == `MSP_TGT_SRAM);
            periph_en_o <= (target == `MSP_TGT_PERIPH);
            target_o <= target;
            rdata_valid_o <= (rd_strobe_i | code_fetch_strobe_i) & (target != `MSP_TGT_NONE);
            rdata_o <= (rd_strobe_i | code_fetch_strobe_i) ? rdata_next : 8'h00;
        end
    end
endmodule

// *** rtl/msp_consts.vh ***
`ifndef MSP_CONSTS_VH
`define MSP_CONSTS_VH

// ****************************************************************
// Control block offsets
// ****************************************************************
`define MSP_OFF_A_IN 8'h00
`define MSP_OFF_B_IN 8'h01
`define MSP_OFF_A_MODE 8'h02
`define MSP_OFF_B_MODE 8'h03
`define MSP_OFF_A_OUT 8'h04
`define MSP_OFF_B_OUT 8'h05
`define MSP_OFF_A_DIR 8'h06
`define MSP_OFF_B_DIR 8'h07
`define MSP_OFF_A_DRV 8'h08
`define MSP_OFF_B_DRV 8'h09
`define MSP_OFF_A_IC 8'h0a
`define MSP_OFF_B_IC 8'h0b
`define MSP_OFF_A_EN 8'h0c
`define MSP_OFF_B_EN 8'h0d
`define MSP_OFF_C_IN 8'h10
`define MSP_OFF_D_IN 8'h11
`define MSP_OFF_C_OUT 8'h12
`define MSP_OFF_D_OUT 8'h13
`define MSP_OFF_C_DIR 8'h14
`define MSP_OFF_D_DIR 8'h15
`define MSP_OFF_C_DRV 8'h16
`define MSP_OFF_D_DRV 8'h17
`define MSP_OFF_C_IC 8'h18
`define MSP_OFF_C_EN 8'h1a
`define MSP_OFF_D_EN 8'h1b
`define MSP_OFF_OC_ONE 8'h20
`define MSP_OFF_OC_TWO 8'h21
`define MSP_OFF_MASK_ONE 8'h22
`define MSP_OFF_MASK_TWO 8'h23
`define MSP_OFF_PWR_ZERO 8'hb0
`define MSP_OFF_PWR_TWO 8'hb4
`define MSP_OFF_FL_PROT 8'hc0
`define MSP_OFF_SEC_PROT 8'hc2
`define MSP_OFF_PWR_THREE 8'hc7
`define MSP_OFF_PAGE 8'he0
`define MSP_OFF_ROUTE 8'he2

// ****************************************************************
// Routing fields, sticky power bit and reset values
// ****************************************************************
`define MSP_RT_MAIN_DATA 4
`define MSP_RT_SEC_DATA 3
`define MSP_RT_MAIN_CODE 2
`define MSP_RT_SEC_CODE 1
`define MSP_RT_SRAM_CODE 0
`define MSP_PWR3_STICKY 1
`define MSP_RST_BYTE 8'h00

// ****************************************************************
// Target codes
// ****************************************************************
`define MSP_TGT_NONE 3'h0
`define MSP_TGT_MAIN 3'h1
`define MSP_TGT_SEC 3'h2
`define MSP_TGT_SRAM 3'h3
`define MSP_TGT_CTRL 3'h4
`define MSP_TGT_PERIPH 3'h5

`endif

// *** rtl/msp_pin_sync.v ***
`include "msp_consts.vh"

// ****************************************************************
// Three-stage pin synchroniser; a change counts once stages two
// and three agree.
// ****************************************************************
module msp_pin_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire clock_i,
    input wire srst_i,
    // Data
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] val_reg;

    always @(posedge clock_i) begin
        if (srst_i) begin
            s1_reg <= {WIDTH{1'b0}};
            s2_reg <= {WIDTH{1'b0}};
            s3_reg <= {WIDTH{1'b0}};
            val_reg <= {WIDTH{1'b0}};
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            val_reg <= (val_reg & (s2_reg ^ s3_reg)) | (s2_reg & ~(s2_reg ^ s3_reg));
        end
    end

    assign sync_o = val_reg;
endmodule

// *** rtl/msp_target_select.v ***
`include "msp_consts.vh"

// ****************************************************************
// Priority and routing of one bus cycle onto one target.
// ****************************************************************
module msp_target_select (
    // Selects
    input wire [7:0] main_flash_sector_select_i,
    input wire [3:0] secondary_flash_sector_select_i,
    input wire sram_select_i,
    input wire ctrl_select_i,
    input wire peripheral_io_select_i,
    // Strobes and routing
    input wire data_strobe_i,
    input wire code_fetch_strobe_i,
    input wire [7:0] route_i,
    // Result
    output reg [2:0] target_o
);
    wire main_ok;
    wire sec_ok;
    wire sram_ok;

    assign main_ok = (data_strobe_i & route_i[`MSP_RT_MAIN_DATA]) |
                     (code_fetch_strobe_i & route_i[`MSP_RT_MAIN_CODE]);
    assign sec_ok = (data_strobe_i & route_i[`MSP_RT_SEC_DATA]) |
                    (code_fetch_strobe_i & route_i[`MSP_RT_SEC_CODE]);
    assign sram_ok = data_strobe_i | (code_fetch_strobe_i & route_i[`MSP_RT_SRAM_CODE]);

    always @* begin
        target_o = `MSP_TGT_NONE;
        if (sram_select_i | ctrl_select_i | peripheral_io_select_i) begin
            if (sram_select_i & sram_ok) begin
                target_o = `MSP_TGT_SRAM;
            end else if (ctrl_select_i & data_strobe_i) begin
                target_o = `MSP_TGT_CTRL;
            end else if (peripheral_io_select_i & data_strobe_i) begin
                target_o = `MSP_TGT_PERIPH;
            end
        end else if (|secondary_flash_sector_select_i) begin
            if (sec_ok) begin
                target_o = `MSP_TGT_SEC;
            end
        end else if ((|main_flash_sector_select_i) & main_ok) begin
            target_o = `MSP_TGT_MAIN;
        end
    end
endmodule

// *** verif/msp_select_monitor.sv ***
module msp_select_monitor (
    // Clock and reset
    input wire logic clock_i,
    input wire logic srst_i,
    // Core bus and selects
    input wire logic [15:0] addr_i,
    input wire logic rd_strobe_i,
    input wire logic wr_strobe_i,
    input wire logic code_fetch_strobe_i,
    input wire logic [15:0] ctrl_base_i,
    input wire logic [7:0] main_flash_sector_select_i,
    input wire logic [3:0] secondary_flash_sector_select_i,
    input wire logic sram_select_i,
    input wire logic peripheral_io_select_i,
    input wire logic [7:0] sram_rdata_i,
    // Targets
    input wire logic main_flash_en_o,
    input wire logic sec_flash_en_o,
    input wire logic sram_en_o,
    input wire logic periph_en_o,
    input wire logic [2:0] target_o,
    input wire logic [7:0] rdata_o,
    input wire logic rdata_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    wire [15:0] ctrl_off = addr_i - ctrl_base_i;
    wire in_ctrl = (addr_i >= ctrl_base_i) && (ctrl_off[15:8] == 8'h00);
    wire dstb = rd_strobe_i | wr_strobe_i;
    wire top = sram_select_i | peripheral_io_select_i | in_ctrl;
    sec_over_main_a: assert property (dstb && !top && |main_flash_sector_select_i
        && |secondary_flash_sector_select_i |=> !main_flash_en_o) else $error("main flash won over secondary");
    top_beats_flash_a: assert property (dstb && sram_select_i |=> !main_flash_en_o && !sec_flash_en_o)
        else $error("flash answered under sram select");
    sram_data_a: assert property (rd_strobe_i && sram_select_i |=> target_o == 3'h3
        && sram_en_o && rdata_o == $past(sram_rdata_i)) else $error("sram data read missed");
    ctrl_no_fetch_a: assert property (code_fetch_strobe_i && in_ctrl |=> target_o != 3'h4)
        else $error("control block answered a fetch");
    ctrl_read_a: assert property (rd_strobe_i && in_ctrl && !sram_select_i |=> target_o == 3'h4 && rdata_valid_o)
        else $error("control read not served");
    idle_none_a: assert property (!dstb && !code_fetch_strobe_i |=> target_o == 3'h0 && !rdata_valid_o)
        else $error("target without strobe");
    rdata_zero_a: assert property (!rdata_valid_o |-> rdata_o == 8'h00)
        else $error("read data without valid");
    one_target_a: assert property ($onehot0({main_flash_en_o, sec_flash_en_o, sram_en_o, periph_en_o})
        && main_flash_en_o == (target_o == 3'h1)) else $error("more than one target enabled");
endmodule

bind msp_memory_select msp_select_monitor u_mon (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .rd_strobe_i(rd_strobe_i),
    .wr_strobe_i(wr_strobe_i), .code_fetch_strobe_i(code_fetch_strobe_i), .ctrl_base_i(ctrl_base_i),
    .main_flash_sector_select_i(main_flash_sector_select_i),
    .secondary_flash_sector_select_i(secondary_flash_sector_select_i), .sram_select_i(sram_select_i),
    .peripheral_io_select_i(peripheral_io_select_i), .sram_rdata_i(sram_rdata_i),
    .main_flash_en_o(main_flash_en_o), .sec_flash_en_o(sec_flash_en_o), .sram_en_o(sram_en_o),
    .periph_en_o(periph_en_o), .target_o(target_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o)
);

// *** verif/msp_core_mem_model.sv ***
module msp_core_mem_model (
    // Address
    input wire logic [15:0] addr_i,
    // Memory read data
    output logic [7:0] main_rdata_o,
    output logic [7:0] sec_rdata_o,
    output logic [7:0] sram_rdata_o,
    output logic [7:0] periph_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each memory marks its data so a wrong source shows up.
    assign main_rdata_o = addr_i[7:0] ^ 8'h10;
    assign sec_rdata_o = addr_i[7:0] ^ 8'h20;
    assign sram_rdata_o = addr_i[7:0] ^ 8'h30;
    assign periph_rdata_o = addr_i[7:0] ^ 8'h50;
endmodule

// *** verif/msp_memory_select_tb.sv ***
`include "msp_consts.vh"

module msp_memory_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [15:0] BASE = 16'h2000;
    reg clock_i = 1'b0;
    reg srst_i = 1'b1;
    reg [15:0] addr = 16'h0000;
    reg [7:0] wdata = 8'h00;
    reg rd = 1'b0;
    reg wr = 1'b0;
    reg cf = 1'b0;
    reg [7:0] ms = 8'h00;
    reg [3:0] ss = 4'h0;
    reg sr = 1'b0;
    reg pe = 1'b0;
    reg [31:0] pins = 32'h9a3c5e71;
    reg [31:0] den = 32'h0f0ff0c3;
    reg [15:0] ocell = 16'hb64d;
    reg [2:0] ct;
    reg [7:0] cd;
    reg cv;
    wire [15:0] cload;
    wire [7:0] pwr3;
    wire [7:0] main_d, sec_d, sram_d, per_d, rdata;
    wire [2:0] tgt;
    wire [31:0] pout, pdir;
    wire [15:0] amode;
    wire rvalid, peripheral_io_enable;
    int fails = 0;
    int comparisons = 0;

    always #10 clock_i = ~clock_i;

    msp_core_mem_model u_mem (.addr_i(addr), .main_rdata_o(main_d), .sec_rdata_o(sec_d),
        .sram_rdata_o(sram_d), .periph_rdata_o(per_d));

    msp_memory_select dut (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr), .wdata_i(wdata),
        .rd_strobe_i(rd), .wr_strobe_i(wr), .code_fetch_strobe_i(cf), .ctrl_base_i(BASE),
        .main_flash_sector_select_i(ms), .secondary_flash_sector_select_i(ss), .sram_select_i(sr),
        .peripheral_io_select_i(pe), .main_rdata_i(main_d), .sec_rdata_i(sec_d), .sram_rdata_i(sram_d),
        .periph_rdata_i(per_d), .pin_level_i(pins), .input_cell_i(24'h000000), .output_cell_i(ocell),
        .cell_drives_pin_i(32'h00000000), .driver_enable_i(den), .main_flash_en_o(), .sec_flash_en_o(),
        .sram_en_o(), .periph_en_o(), .target_o(tgt), .rdata_o(rdata), .rdata_valid_o(rvalid),
        .pin_out_o(pout), .pin_dir_o(pdir), .addr_out_mode_o(amode), .driver_type_o(),
        .output_cell_load_o(cload), .output_cell_load_en_o(), .memory_page_o(), .peripheral_io_enable_o(peripheral_io_enable),
        .power_zero_o(), .power_two_o(), .power_three_o(pwr3));

    task give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input string what, input [7:0] exp, input [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One request cycle, then one idle cycle so writes are spaced.
    task cyc(input [1:0] k, input [15:0] a, input [7:0] d);
        addr = a;
        wdata = d;
        rd = (k == 2'd1);
        wr = (k == 2'd2);
        cf = (k == 2'd3);
        @(posedge clock_i);
        #1;
        ct = tgt;
        cd = rdata;
        cv = rvalid;
        rd = 1'b0;
        wr = 1'b0;
        cf = 1'b0;
        @(posedge clock_i);
        #1;
    endtask

    task wreg(input [7:0] o, input [7:0] d);
        cyc(2'd2, BASE + {8'h00, o}, d);
    endtask

    task rreg(input [7:0] o, input [7:0] e);
        cyc(2'd1, BASE + {8'h00, o}, 8'h00);
        chk($sformatf("register %h", o), e, cd);
    endtask

    // Only one select per priority level is ever raised.
    task hit(input [1:0] k, input [7:0] m, input [3:0] s, input r, input p, input [15:0] a, input [2:0] e);
        ms = m;
        ss = s;
        sr = r;
        pe = p;
        cyc(k, a, 8'h5a);
        chk("target", {5'h00, e}, {5'h00, ct});
        chk("read valid", {7'h00, k != 2'd2 && e != `MSP_TGT_NONE}, {7'h00, cv});
        if (k != 2'd2 && e != `MSP_TGT_NONE && e != `MSP_TGT_CTRL)
            chk("read data", a[7:0] ^ {1'b0, e, 4'h0}, cd);
        ms = 8'h00;
        ss = 4'h0;
        sr = 1'b0;
        pe = 1'b0;
    endtask

    initial begin
        repeat (4000) @(posedge clock_i);
        fails++;
        give_verdict;
    end

    initial begin
        repeat (16) @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        rreg(8'he2, 8'h0c);
        rreg(8'h30, 8'h00);
        $display("test reset defaults done");
        wreg(8'h02, 8'ha5);
        rreg(8'h02, 8'ha5);
        chk("mode output", 8'ha5, amode[7:0]);
        wreg(8'h06, 8'h3c);
        chk("direction output", 8'h3c, pdir[7:0]);
        wreg(8'h05, 8'h5a);
        rreg(8'h05, 8'h5a);
        chk("pin output", 8'h5a, pout[15:8]);
        wreg(8'h00, 8'hff);
        rreg(8'h00, pins[7:0]);
        pins[7:0] = 8'h0e;
        repeat (4) @(posedge clock_i);
        #1;
        rreg(8'h00, 8'h0e);
        wreg(8'h0d, 8'h00);
        rreg(8'h0d, den[15:8]);
        wreg(8'h0c, 8'h77);
        rreg(8'h0c, den[7:0]);
        wreg(8'h22, 8'hff);
        rreg(8'h20, 8'h00);
        wreg(8'h20, 8'h00);
        chk("cell load", ocell[7:0], cload[7:0]);
        wreg(8'h22, 8'h00);
        rreg(8'h20, ocell[7:0]);
        wreg(8'h20, 8'h81);
        chk("cell load", 8'h81, cload[7:0]);
        wreg(8'hc7, 8'h02);
        wreg(8'hc7, 8'h05);
        rreg(8'hc7, 8'h07);
        chk("power three", 8'h07, pwr3);
        $display("test control registers done");
        for (int i = 0; i < 5; i++) begin
            wreg(8'he2, 8'h01 << i);
            hit(2'd1, 8'h01, 4'h0, 1'b0, 1'b0, 16'h4000, i == 4 ? `MSP_TGT_MAIN : `MSP_TGT_NONE);
            hit(2'd1, 8'h00, 4'h1, 1'b0, 1'b0, 16'h8000, i == 3 ? `MSP_TGT_SEC : `MSP_TGT_NONE);
            hit(2'd3, 8'h01, 4'h0, 1'b0, 1'b0, 16'h4000, i == 2 ? `MSP_TGT_MAIN : `MSP_TGT_NONE);
            hit(2'd3, 8'h00, 4'h1, 1'b0, 1'b0, 16'h8000, i == 1 ? `MSP_TGT_SEC : `MSP_TGT_NONE);
            hit(2'd3, 8'h00, 4'h0, 1'b1, 1'b0, 16'h0100, i == 0 ? `MSP_TGT_SRAM : `MSP_TGT_NONE);
            hit(2'd1, 8'h00, 4'h0, 1'b1, 1'b0, 16'h0100, `MSP_TGT_SRAM);
        end
        $display("test space routing done");
        wreg(8'he2, 8'h9f);
        rreg(8'he2, 8'h9f);
        chk("io enable", 8'h01, {7'h00, peripheral_io_enable});
        hit(2'd1, 8'h01, 4'h1, 1'b0, 1'b0, 16'h8000, `MSP_TGT_SEC);
        hit(2'd2, 8'h01, 4'h1, 1'b0, 1'b0, 16'h8000, `MSP_TGT_SEC);
        hit(2'd1, 8'h01, 4'h1, 1'b1, 1'b0, 16'h8000, `MSP_TGT_SRAM);
        hit(2'd1, 8'h01, 4'h0, 1'b0, 1'b1, 16'h4000, `MSP_TGT_PERIPH);
        hit(2'd1, 8'h00, 4'h1, 1'b0, 1'b0, BASE + 16'h0005, `MSP_TGT_CTRL);
        hit(2'd3, 8'h01, 4'h0, 1'b0, 1'b0, BASE + 16'h0005, `MSP_TGT_NONE);
        $display("test priority done");
        srst_i = 1'b1;
        @(posedge clock_i);
        #1;
        srst_i = 1'b0;
        rreg(8'he2, 8'h0c);
        chk("io enable", 8'h00, {7'h00, peripheral_io_enable});
        rreg(8'hc7, 8'h00);
        $display("test second reset done");
        give_verdict;
    end
endmodule
